/* File: sarcs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module sarcs_chk
#(
   parameter int STEP_CYC = 62
)
(
   input wire logic       i_clk,
   input wire logic       i_reset,
   input wire logic       i_convert,
   input wire logic       i_comp_gt,
   input wire logic       i_range_open,
   input wire logic       i_data_enable_n,
   input wire logic       o_conversion_done_n,
   input wire logic [7:0] o_dac_code,
   input wire logic       o_bipolar_offset_en,
   input wire logic [7:0] o_data,
   input wire logic       o_data_oe
);
   // ----------
   // Cycles since convert fell
   // ----------
   logic [15:0] cnt_reg;
   always_ff @(posedge i_clk)
   begin
      if (i_reset || i_convert)
         cnt_reg <= 16'h0000;
      else if (o_conversion_done_n)
         cnt_reg <= cnt_reg + 16'h0001;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   sequence s_start;
      $fell(i_convert) && o_conversion_done_n && o_dac_code == 8'h00;
   endsequence
   sequence s_held;
      !o_conversion_done_n ##1 !o_conversion_done_n;
   endsequence
   property p_rise;
      $rose(i_convert) |=> o_conversion_done_n && o_dac_code == 8'h00;
   endproperty
   a_rise: assert property (p_rise) else $error("no clear on rise");
   property p_wait;
      i_convert && $past(i_convert) |-> o_dac_code == 8'h00;
   endproperty
   a_wait: assert property (p_wait) else $error("trial while high");
   property p_msb;
      s_start |=> o_dac_code == 8'h80;
   endproperty
   a_msb: assert property (p_msb) else $error("first trial wrong");
   property p_range;
      s_start |=> o_bipolar_offset_en == $past(i_range_open);
   endproperty
   a_range: assert property (p_range) else $error("offset wrong");
   property p_time;
      $fell(o_conversion_done_n) |-> cnt_reg == 16'(8 * STEP_CYC + 1);
   endproperty
   a_time: assert property (p_time) else $error("length wrong");
   property p_keep;
      s_held |-> $stable(o_dac_code) && o_data == o_dac_code;
   endproperty
   a_keep: assert property (p_keep) else $error("result moved");
   property p_oe;
      $fell(i_data_enable_n) |=> o_data_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("no drive");
   property p_float;
      i_data_enable_n ##1 i_data_enable_n |-> !o_data_oe;
   endproperty
   a_float: assert property (p_float) else $error("no float");
endmodule
bind sarcs_sequencer sarcs_chk #(.STEP_CYC(STEP_CYC)) sarcs_chk_inst (.*);
`default_nettype wire

/* File: sarcs_cfg.svh */
`ifndef SARCS_CFG_SVH
`define SARCS_CFG_SVH

// ----------------------------------------
// Widths and codes
// ----------------------------------------
`define SARCS_RES_BITS      8
`define SARCS_MSB_IDX      3'h7
`define SARCS_CODE_ZERO    8'h00
`define SARCS_CODE_MSB     8'h80

// ----------------------------------------
// Timing, in ns at the 25 MHz clock
// ----------------------------------------
`define SARCS_CLK_NS        40
`define SARCS_CONV_PULSE_NS 500
`define SARCS_RESET_MAX_NS  1500
`define SARCS_CONV_MIN_NS   10000
`define SARCS_CONV_TYP_NS   20000
`define SARCS_CONV_MAX_NS   30000

// Least times round up, longest times round down
`define SARCS_CONV_PULSE_CYC ((`SARCS_CONV_PULSE_NS + `SARCS_CLK_NS - 1) / `SARCS_CLK_NS)
`define SARCS_RESET_MAX_CYC  (`SARCS_RESET_MAX_NS / `SARCS_CLK_NS)
`define SARCS_CONV_MIN_CYC   ((`SARCS_CONV_MIN_NS + `SARCS_CLK_NS - 1) / `SARCS_CLK_NS)
`define SARCS_CONV_TYP_CYC   (`SARCS_CONV_TYP_NS / `SARCS_CLK_NS)
`define SARCS_CONV_MAX_CYC   (`SARCS_CONV_MAX_NS / `SARCS_CLK_NS)
// One bit trial period, so eight trials land near the typical time
`define SARCS_STEP_CYC       (`SARCS_CONV_TYP_CYC / `SARCS_RES_BITS)

`endif

/* File: sarcs_comp_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------
// Comparator model
// ----------
module sarcs_comp_model
(
   input  wire logic              [7:0] i_dac_code,
   input  wire logic                    i_bipolar_offset_en,
   input  wire logic signed       [9:0] i_vin,
   output logic                         o_comp_gt
);
   // Input as signed LSB count; ideal ladder, so no noise near a code edge
   assign o_comp_gt = ($signed({2'b00, i_dac_code}) - (i_bipolar_offset_en ? 10'sh080 : 10'sh000)) > i_vin;
endmodule
`default_nettype wire

/* File: sarcs_pkg.sv */
package sarcs_pkg;

   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {
      SARCS_IDLE  = 2'h0,
      SARCS_ARMED = 2'h1,
      SARCS_RUN   = 2'h2,
      SARCS_DONE  = 2'h3
   } sarcs_state_t;

   // ----------------------------------------
   // One-hot mask of a bit position
   // ----------------------------------------
   function automatic logic [7:0] sarcs_bit_mask(input logic [2:0] idx);
      sarcs_bit_mask = 8'h01 << idx;
   endfunction

endpackage

/* File: sarcs_sequencer.sv */
// Functional notes
// [RULE1] Host holds convert high at least 500 ns before dropping it.
// [RULE2] Convert rising edge clears sequencing and raises done_n within 1.5 us.
// [RULE3] Bit trials start on the convert falling edge only.
// [RULE4] Trial bits run from most to least significant of eight.
// [RULE5] A trial bit is cleared when the DAC sum exceeds the input.
// [RULE6] After the last trial done_n falls; the code is at the buffers. The final code reaches o_data one cycle after done_n falls.
// [RULE7] Enable low after done drives all eight result bits out.
// [RULE8] Enable high floats the data outputs; host releases it before converting.
// [RULE9] Start to done lasts between 10 and 30 us, 20 typical.
// [RULE10] Unipolar gives straight binary, bipolar gives offset binary.
// [RULE11] Range input open adds MSB less half LSB offset, bipolar range.
// [RULE12] Range input grounded for the whole conversion selects unipolar.
// [RULE13] Bipolar: minus full scale 00h, zero 80h, plus full scale FFh.
// [RULE14] Result stays in the register until the next convert pulse.
`timescale 1ns/1ps
`default_nettype none
`include "sarcs_cfg.svh"

module sarcs_sequencer
   import sarcs_pkg::*;
#(
   parameter int STEP_CYC = `SARCS_STEP_CYC
)
(
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   input  wire logic       i_convert,
   input  wire logic       i_comp_gt,
   input  wire logic       i_range_open,
   input  wire logic       i_data_enable_n,
   output logic            o_conversion_done_n,
   output logic      [7:0] o_dac_code,
   output logic            o_bipolar_offset_en,
   output logic      [7:0] o_data,
   output logic            o_data_oe
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   localparam logic [9:0] STEP_LAST = 10'(STEP_CYC - 1);

   // Sequencer
   sarcs_state_t state_reg;
   sarcs_state_t state_next;

   // Convert edges
   logic         conv_prev_reg;
   logic         conv_rise;
   logic         conv_fall;

   // Trials
   logic   [2:0] bit_idx_reg;
   logic   [9:0] step_cnt_reg;
   logic         step_end;
   logic         trial_clear;
   logic         trial_load;
   logic         trial_decide;
   logic         last_decide;
   logic   [7:0] trial_code;

   // Output registers
   logic         done_n_reg;
   logic         range_reg;
   logic   [7:0] data_reg;
   logic         data_oe_reg;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   // Shared so state, index and flag agree on the last trial
   function automatic logic is_last_bit(input logic [2:0] idx);
      is_last_bit = (idx == 3'h0);
   endfunction

   // ----------------------------------------
   // Convert edge detection
   // ----------------------------------------
   // Resets to the idle low level, so no false rise follows reset
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         conv_prev_reg <= 1'b0;
      end
      else
      begin
         conv_prev_reg <= i_convert;
      end
   end

   // ----------------------------------------
   // Edge decode
   // ----------------------------------------
   // Pulse width is the host's duty; any high level arms
   assign conv_rise = i_convert & ~conv_prev_reg; // RULE2
   assign conv_fall = ~i_convert & conv_prev_reg; // RULE1

   // ----------------------------------------
   // Sequencer state
   // ----------------------------------------
   // Last cycle of one trial period
   assign step_end = (step_cnt_reg == STEP_LAST);

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         SARCS_IDLE:
         begin
            if (conv_rise)
            begin
               state_next = SARCS_ARMED;
            end
         end
         SARCS_ARMED:
         begin
            // A fall outside this state is ignored
            if (conv_fall)
            begin
               state_next = SARCS_RUN; // RULE3
            end
         end
         SARCS_RUN:
         begin
            if (conv_rise)
            begin
               state_next = SARCS_ARMED;
            end
            else if (last_decide)
            begin
               state_next = SARCS_DONE; // RULE6
            end
         end
         SARCS_DONE:
         begin
            if (conv_rise)
            begin
               state_next = SARCS_ARMED;
            end
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // A convert rise restarts from any state
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         state_reg <= SARCS_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------
   // Trial control
   // ----------------------------------------
   // A rising edge restarts even mid-sequence, as the part's logic does
   assign trial_clear  = conv_rise; // RULE2
   assign trial_load   = (state_reg == SARCS_ARMED) && conv_fall; // RULE3
   assign trial_decide = (state_reg == SARCS_RUN) && !conv_rise && step_end; // RULE5
   assign last_decide  = trial_decide && is_last_bit(bit_idx_reg); // RULE6

   // ----------------------------------------
   // Trial period counter
   // ----------------------------------------
   // Fixed trial period keeps 8 trials inside the window
   // Reloaded by each start, so a restart begins a full period
   always_ff @(posedge i_clk)
   begin
      if (i_reset || trial_load || trial_decide)
      begin
         step_cnt_reg <= 10'h000; // RULE9
      end
      else if (state_reg == SARCS_RUN)
      begin
         step_cnt_reg <= step_cnt_reg + 10'h001;
      end
   end

   // ----------------------------------------
   // Bit index
   // ----------------------------------------
   // Stops at the LSB; the ready flag takes over from there
   always_ff @(posedge i_clk)
   begin
      if (i_reset || trial_load)
      begin
         bit_idx_reg <= `SARCS_MSB_IDX; // RULE4
      end
      else if (trial_decide && !is_last_bit(bit_idx_reg))
      begin
         bit_idx_reg <= bit_idx_reg - 3'h1; // RULE4
      end
   end

   // ----------------------------------------
   // Trial register
   // ----------------------------------------
   // Code register sits in the trial unit, so the DAC code is a flop
   sarcs_trial_reg u_trial
   (
      .i_clk      (i_clk),
      .i_reset    (i_reset),
      .i_clear    (trial_clear),
      .i_load_msb (trial_load),
      .i_decide   (trial_decide),
      .i_comp_gt  (i_comp_gt),
      .i_bit_idx  (bit_idx_reg),
      .o_code     (trial_code)
   );

   // ----------------------------------------
   // Ready flag
   // ----------------------------------------
   // Not ready out of reset: no valid code yet
   // A cut run never reaches the last trial, so never reports done
   always_ff @(posedge i_clk)
   begin
      if (i_reset || conv_rise)
      begin
         done_n_reg <= 1'b1; // RULE2
      end
      else if (last_decide)
      begin
         done_n_reg <= 1'b0; // RULE6
      end
   end

   // ----------------------------------------
   // Range select
   // ----------------------------------------
   // Latched at start so a mid-conversion change cannot corrupt it
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         range_reg <= 1'b0;
      end
      else if (trial_load)
      begin
         range_reg <= i_range_open; // RULE11
      end
   end

   // ----------------------------------------
   // Offset switch
   // ----------------------------------------
   // Offset is analog; the SAR code itself gives the offset binary
   // mapping 00h, 80h, FFh across the bipolar span
   assign o_bipolar_offset_en = range_reg; // RULE10 RULE13

   // ----------------------------------------
   // Output buffers
   // ----------------------------------------
   // One cycle behind the code, so the pins stay flop driven
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         data_reg <= `SARCS_CODE_ZERO;
      end
      else
      begin
         data_reg <= trial_code; // RULE7
      end
   end

   // ----------------------------------------
   // Output enable
   // ----------------------------------------
   // Not gated by ready: an early read sees the trial code
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         data_oe_reg <= 1'b0; // RULE8
      end
      else
      begin
         data_oe_reg <= ~i_data_enable_n; // RULE7 RULE8
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Every output leaves straight from a flop
   assign o_conversion_done_n = done_n_reg;
   assign o_dac_code          = trial_code;
   assign o_data              = data_reg;
   assign o_data_oe           = data_oe_reg;

endmodule
`default_nettype wire

/* File: sarcs_trial_reg.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sarcs_cfg.svh"

module sarcs_trial_reg
   import sarcs_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   input  wire logic       i_clear,
   input  wire logic       i_load_msb,
   input  wire logic       i_decide,
   input  wire logic       i_comp_gt,
   input  wire logic [2:0] i_bit_idx,
   output logic      [7:0] o_code
);

   logic [7:0] code_reg;
   logic [7:0] code_next;

   // ----------------------------------------
   // Trial decision
   // ----------------------------------------
   always_comb
   begin
      code_next = code_reg;
      if (i_comp_gt)
      begin
         code_next = code_next & ~sarcs_bit_mask(i_bit_idx); // RULE5
      end
      if (i_bit_idx != 3'h0)
      begin
         code_next = code_next | sarcs_bit_mask(i_bit_idx - 3'h1); // RULE4
      end
   end

   // Untouched outside a sequence, so the result holds
   always_ff @(posedge i_clk)
   begin
      if (i_reset || i_clear)
      begin
         code_reg <= `SARCS_CODE_ZERO; // RULE2
      end
      else if (i_load_msb)
      begin
         code_reg <= `SARCS_CODE_MSB; // RULE4
      end
      else if (i_decide)
      begin
         code_reg <= code_next; // RULE14
      end
   end

   assign o_code = code_reg;

endmodule
`default_nettype wire

/* File: test_sar_conversion_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module test_sar_conversion_sequencer;
   // Short step: 24 cycles a conversion
   localparam int STEP = 3;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              conv = 1'b0;
   logic              rng = 1'b0;
   logic              den_n = 1'b1;
   logic signed [9:0] vin = 10'h000;
   logic              gt;
   logic              done_n;
   logic              boff;
   logic              oe;
   logic        [7:0] dac;
   logic        [7:0] data;
   int                err_total = 0;
   int                checked = 0;
   sarcs_sequencer #(.STEP_CYC(STEP)) sarcs_sequencer_inst (.i_clk(clk), .i_reset(rst),
      .i_convert(conv), .i_comp_gt(gt), .i_range_open(rng), .i_data_enable_n(den_n),
      .o_conversion_done_n(done_n), .o_dac_code(dac), .o_bipolar_offset_en(boff),
      .o_data(data), .o_data_oe(oe));
   sarcs_comp_model sarcs_comp_model_inst (.i_dac_code(dac), .i_bipolar_offset_en(boff),
      .i_vin(vin), .o_comp_gt(gt));
   initial forever #20 clk = ~clk;
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("mismatches %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic convert_once(input logic [9:0] v, input logic r, input logic [7:0] exp);
      int n;
      vin = v;
      rng = r;
      conv = 1'b1;
      cyc(1);
      chk({7'h00, done_n}, 8'h01);
      chk(dac, 8'h00);
      cyc(12);
      chk(dac, 8'h00);
      conv = 1'b0;
      cyc(1);
      chk(dac, 8'h80);
      for (n = 0; done_n !== 1'b0 && n < 999; n++)
         cyc(1);
      chk(8'(n), 8'(8 * STEP));
      chk(dac, exp);
      chk({7'h00, boff}, {7'h00, r});
   endtask
   task automatic read_out(input logic [7:0] exp);
      den_n = 1'b0;
      cyc(1);
      chk({7'h00, oe}, 8'h01);
      chk(data, exp);
      den_n = 1'b1;
      cyc(1);
      chk({7'h00, oe}, 8'h00);
   endtask
   task automatic t_unipolar;
      logic [7:0] tbl [6] = '{8'h00, 8'hFF, 8'h80, 8'h7F, 8'h55, 8'h01};
      foreach (tbl[i])
      begin
         convert_once({2'b00, tbl[i]}, 1'b0, tbl[i]);
         read_out(tbl[i]);
      end
   endtask
   task automatic t_bipolar;
      convert_once(10'h380, 1'b1, 8'h00);
      convert_once(10'h000, 1'b1, 8'h80);
      convert_once(10'h07F, 1'b1, 8'hFF);
      read_out(8'hFF);
   endtask
   task automatic t_hold;
      convert_once(10'h0C3, 1'b0, 8'hC3);
      vin = 10'h000;
      cyc(20);
      chk(dac, 8'hC3);
      chk({7'h00, done_n}, 8'h00);
   endtask
   task automatic t_restart;
      vin = 10'h033;
      conv = 1'b1;
      cyc(13);
      conv = 1'b0;
      cyc(8);
      convert_once(10'h0A6, 1'b0, 8'hA6);
   endtask
   task automatic t_reset;
      rng = 1'b1;
      conv = 1'b1;
      cyc(13);
      conv = 1'b0;
      den_n = 1'b0;
      cyc(5);
      chk({6'h00, boff, oe}, 8'h03);
      rst = 1'b1;
      cyc(2);
      chk({4'h0, done_n, boff, oe, 1'b0}, 8'h08);
      chk(dac | data, 8'h00);
      rst = 1'b0;
      den_n = 1'b1;
      cyc(1);
      convert_once(10'h05A, 1'b0, 8'h5A);
   endtask
   initial
   begin
      cyc(4);
      rst = 1'b0;
      t_unipolar();
      t_bipolar();
      t_hold();
      t_restart();
      t_reset();
      summarize();
   end
   // About 540 cycles expected; allow several times that
   initial
   begin
      #160000;
      err_total++;
      summarize();
   end
endmodule
`default_nettype wire
